// ===== ser_pkg.sv
// Constants, register layout and state types of the sensor exposure timing register bank
package ser_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam int          SER_AW             = 4;
   localparam int          SER_DW             = 16;
   localparam logic [3:0]  SER_OFS_INTEG_CTRL = 4'h2;
   localparam logic [3:0]  SER_OFS_REGION     = 4'h4;
   localparam logic [3:0]  SER_OFS_DARK       = 4'h5;
   localparam logic [3:0]  SER_OFS_PAD        = 4'h6;
   localparam logic [3:0]  SER_OFS_PRESC      = 4'h7;
   localparam logic [3:0]  SER_OFS_PERIOD     = 4'h8;
   localparam logic [3:0]  SER_OFS_INTEG      = 4'h9;
   localparam logic [3:0]  SER_OFS_SPARE_A    = 4'ha;
   localparam logic [3:0]  SER_OFS_SPARE_B    = 4'hb;
   localparam logic [3:0]  SER_OFS_GAIN       = 4'hc;
   localparam logic [3:0]  SER_OFS_SYNC       = 4'he;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] SER_INTEG_CTRL_RST = 16'h0004;
   localparam logic [15:0] SER_REGION_RST     = 16'h0000;
   localparam logic [15:0] SER_DARK_RST       = 16'h0102;
   localparam logic [15:0] SER_PAD_RST        = 16'h0000;
   localparam logic [15:0] SER_PRESC_RST      = 16'h0001;
   localparam logic [15:0] SER_PERIOD_RST     = 16'h0000;
   localparam logic [15:0] SER_INTEG_RST      = 16'h0000;
   localparam logic [15:0] SER_SPARE_RST      = 16'h0000;
   localparam logic [15:0] SER_GAIN_RST       = 16'h01e2;
   localparam logic [15:0] SER_SYNC_RST       = 16'h033f;
   localparam logic [15:0] SER_RDATA_UNMAPPED = 16'h0000;
   localparam logic [15:0] SER_ZERO           = 16'h0000;
   localparam logic [15:0] SER_ONE            = 16'h0001;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int          SER_BIT_PERIOD_MODE = 2;
   localparam int          SER_BIT_GATE_FIRST  = 8;
   localparam int          SER_BIT_SYNC_DARK   = 1;
   localparam int          SER_BIT_SYNC_PAD    = 2;
   localparam int          SER_BIT_SYNC_EXP    = 3;
   localparam int          SER_REGION_LSB      = 7;
   localparam int          SER_REGION_MSB      = 15;
   localparam int          SER_DARK_MSB        = 7;
   localparam int          SER_PAD_MSB         = 11;
   localparam int          SER_GAIN_MSB        = 4;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic [15:0] integ_ctrl;
      logic [15:0] region;
      logic [15:0] dark;
      logic [15:0] pad;
      logic [15:0] presc;
      logic [15:0] period;
      logic [15:0] integ;
      logic [15:0] spare_a;
      logic [15:0] spare_b;
      logic [15:0] gain;
      logic [15:0] sync;
   } ser_regs_t;

   typedef struct packed {
      logic [8:0]  region_en;
      logic [7:0]  dark_rows;
      logic        gate_first;
      logic [11:0] padding_rows;
      logic [15:0] exp_lines;
      logic [15:0] exp_ticks;
      logic [15:0] reset_len;
      logic [15:0] frame_len;
      logic [15:0] prescale;
      logic [4:0]  col_gain;
   } ser_timing_t;

   typedef struct packed {
      ser_regs_t   regs;
      logic [7:0]  act_dark;
      logic [11:0] act_pad;
      logic [15:0] act_period;
      logic [15:0] act_integ;
      logic [15:0] tick_cnt;
      logic        tick;
      logic        blank;
      logic [15:0] rdata;
      ser_timing_t out;
   } ser_state_t;

   localparam ser_regs_t SER_REGS_RST = '{
      integ_ctrl: SER_INTEG_CTRL_RST, region: SER_REGION_RST, dark: SER_DARK_RST,
      pad: SER_PAD_RST, presc: SER_PRESC_RST, period: SER_PERIOD_RST,
      integ: SER_INTEG_RST, spare_a: SER_SPARE_RST, spare_b: SER_SPARE_RST,
      gain: SER_GAIN_RST, sync: SER_SYNC_RST};

   localparam ser_timing_t SER_TIMING_RST = '{
      region_en: SER_REGION_RST[SER_REGION_MSB:SER_REGION_LSB],
      dark_rows: SER_DARK_RST[SER_DARK_MSB:0],
      gate_first: SER_DARK_RST[SER_BIT_GATE_FIRST],
      padding_rows: SER_PAD_RST[SER_PAD_MSB:0],
      exp_lines: SER_INTEG_RST, exp_ticks: SER_ZERO, reset_len: SER_ZERO,
      frame_len: SER_ZERO, prescale: SER_PRESC_RST,
      col_gain: SER_GAIN_RST[SER_GAIN_MSB:0]};

   localparam ser_state_t SER_STATE_RST = '{
      regs: SER_REGS_RST, act_dark: SER_DARK_RST[SER_DARK_MSB:0],
      act_pad: SER_PAD_RST[SER_PAD_MSB:0], act_period: SER_PERIOD_RST,
      act_integ: SER_INTEG_RST, tick_cnt: SER_ZERO, tick: 1'b0, blank: 1'b0,
      rdata: SER_ZERO, out: SER_TIMING_RST};

endpackage

// ===== ser_exposure_regs.sv
// Exposure timing register bank with frame-synchronous shadowing and tick prescaler
`timescale 1ns/1ps

module ser_exposure_regs
   import ser_pkg::*;
(
   input  wire logic              CLOCK,
   input  wire logic              RST_N,
   input  wire logic              WR_EN,
   input  wire logic              RD_EN,
   input  wire logic [SER_AW-1:0] ADDR,
   input  wire logic [SER_DW-1:0] WR_DATA,
   output logic      [SER_DW-1:0] RD_DATA,
   input  wire logic              FRAME_START,
   input  wire logic              FIRST_LINE,
   input  wire logic              SHUTTER_GLOBAL,
   output logic                   BLANK_LINE,
   output logic                   TICK,
   output ser_timing_t            CFG
);

   // ****************************************
   // State
   // ****************************************
   ser_state_t  st_q;
   ser_state_t  st_d;
   logic [15:0] tick_lim;
   logic        sync_dark;
   logic        sync_pad;
   logic        sync_exp;
   logic        period_is_frame;

   assign RD_DATA    = st_q.rdata;
   assign BLANK_LINE = st_q.blank;
   assign TICK       = st_q.tick;
   assign CFG        = st_q.out;

   // Sync bits act from the cycle after they are written
   assign sync_dark = st_q.regs.sync[SER_BIT_SYNC_DARK];
   assign sync_pad  = st_q.regs.sync[SER_BIT_SYNC_PAD];
   assign sync_exp  = st_q.regs.sync[SER_BIT_SYNC_EXP];

   // A prescaler of zero would never tick, so it counts as one
   assign tick_lim = (st_q.regs.presc == SER_ZERO) ? SER_ONE : st_q.regs.presc;

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      st_d = st_q;
      period_is_frame = 1'b0;

      // Writes store all sixteen bits, unused ones included
      if (WR_EN)
      begin
         case (ADDR)
            SER_OFS_INTEG_CTRL: st_d.regs.integ_ctrl = WR_DATA;
            SER_OFS_REGION:     st_d.regs.region     = WR_DATA;
            SER_OFS_DARK:       st_d.regs.dark       = WR_DATA;
            SER_OFS_PAD:        st_d.regs.pad        = WR_DATA;
            SER_OFS_PRESC:      st_d.regs.presc      = WR_DATA;
            SER_OFS_PERIOD:     st_d.regs.period     = WR_DATA;
            SER_OFS_INTEG:      st_d.regs.integ      = WR_DATA;
            SER_OFS_SPARE_A:    st_d.regs.spare_a    = WR_DATA;
            SER_OFS_SPARE_B:    st_d.regs.spare_b    = WR_DATA;
            SER_OFS_GAIN:       st_d.regs.gain       = WR_DATA;
            SER_OFS_SYNC:       st_d.regs.sync       = WR_DATA;
            default:            st_d.regs            = st_q.regs;
         endcase
      end

      // Read data is registered and holds until the next read
      if (RD_EN)
      begin
         case (ADDR)
            SER_OFS_INTEG_CTRL: st_d.rdata = st_q.regs.integ_ctrl;
            SER_OFS_REGION:     st_d.rdata = st_q.regs.region;
            SER_OFS_DARK:       st_d.rdata = st_q.regs.dark;
            SER_OFS_PAD:        st_d.rdata = st_q.regs.pad;
            SER_OFS_PRESC:      st_d.rdata = st_q.regs.presc;
            SER_OFS_PERIOD:     st_d.rdata = st_q.regs.period;
            SER_OFS_INTEG:      st_d.rdata = st_q.regs.integ;
            SER_OFS_SPARE_A:    st_d.rdata = st_q.regs.spare_a;
            SER_OFS_SPARE_B:    st_d.rdata = st_q.regs.spare_b;
            SER_OFS_GAIN:       st_d.rdata = st_q.regs.gain;
            SER_OFS_SYNC:       st_d.rdata = st_q.regs.sync;
            default:            st_d.rdata = SER_RDATA_UNMAPPED;
         endcase
      end

      // Shadow copies take the value written in the same cycle as the frame start
      if (!sync_dark || FRAME_START)
      begin
         st_d.act_dark = st_d.regs.dark[SER_DARK_MSB:0];
      end
      if (!sync_pad || FRAME_START)
      begin
         st_d.act_pad = st_d.regs.pad[SER_PAD_MSB:0];
      end
      if (!sync_exp || FRAME_START)
      begin
         st_d.act_integ  = st_d.regs.integ;
         st_d.act_period = st_d.regs.period;
      end

      // Tick generator runs only in global shutter operation
      st_d.tick = 1'b0;
      if (SHUTTER_GLOBAL)
      begin
         if (st_q.tick_cnt >= tick_lim - SER_ONE)
         begin
            st_d.tick_cnt = SER_ZERO;
            st_d.tick     = 1'b1;
         end
         else
         begin
            st_d.tick_cnt = st_q.tick_cnt + SER_ONE;
         end
      end
      else
      begin
         st_d.tick_cnt = SER_ZERO;
      end

      st_d.blank = FIRST_LINE && st_q.regs.dark[SER_BIT_GATE_FIRST];

      // Timing view handed to the sequencer
      period_is_frame        = st_d.regs.integ_ctrl[SER_BIT_PERIOD_MODE];
      st_d.out.region_en     = st_d.regs.region[SER_REGION_MSB:SER_REGION_LSB];
      st_d.out.dark_rows     = st_d.act_dark;
      st_d.out.gate_first    = st_d.regs.dark[SER_BIT_GATE_FIRST];
      st_d.out.padding_rows  = SHUTTER_GLOBAL ? '0 : st_d.act_pad;
      st_d.out.exp_lines     = SHUTTER_GLOBAL ? SER_ZERO : st_d.act_integ;
      st_d.out.exp_ticks     = SHUTTER_GLOBAL ? st_d.act_integ : SER_ZERO;
      st_d.out.reset_len     = (SHUTTER_GLOBAL && !period_is_frame) ?
                               st_d.act_period : SER_ZERO;
      st_d.out.frame_len     = (SHUTTER_GLOBAL && period_is_frame) ?
                               st_d.act_period : SER_ZERO;
      st_d.out.prescale      = st_d.regs.presc;
      st_d.out.col_gain      = st_d.regs.gain[SER_GAIN_MSB:0];
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
      begin
         st_q <= SER_STATE_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_region_write;
      @(posedge CLOCK) disable iff (!RST_N)
      (WR_EN && ADDR == SER_OFS_REGION) |=>
         (CFG.region_en == $past(WR_DATA[SER_REGION_MSB:SER_REGION_LSB]));
   endproperty
   a_region_write: assert property (p_region_write) else $error("region enables wrong");

   property p_region_reset;
      @(posedge CLOCK)
      (!RST_N) |=> (CFG.region_en == '0 && CFG.dark_rows == SER_DARK_RST[SER_DARK_MSB:0]);
   endproperty
   a_region_reset: assert property (p_region_reset) else $error("reset fields wrong");

   property p_blank_line;
      @(posedge CLOCK) disable iff (!RST_N)
      (FIRST_LINE && !WR_EN) ##1 (!WR_EN) |->
         (BLANK_LINE == st_q.regs.dark[SER_BIT_GATE_FIRST]);
   endproperty
   a_blank_line: assert property (p_blank_line) else $error("first line gating wrong");

   property p_pad_global;
      @(posedge CLOCK) disable iff (!RST_N)
      SHUTTER_GLOBAL |=> (CFG.padding_rows == '0);
   endproperty
   a_pad_global: assert property (p_pad_global) else $error("padding used in global");

   property p_tick_spacing;
      @(posedge CLOCK) disable iff (!RST_N)
      (TICK && SHUTTER_GLOBAL && st_q.regs.presc == 16'h0003 && !WR_EN)
         ##1 (SHUTTER_GLOBAL && !WR_EN && st_q.regs.presc == 16'h0003) [*3]
         |-> (TICK && !$past(TICK) && !$past(TICK, 2));
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("tick period wrong");

   property p_period_reset_len;
      @(posedge CLOCK) disable iff (!RST_N)
      (SHUTTER_GLOBAL && !st_d.regs.integ_ctrl[SER_BIT_PERIOD_MODE]) |=>
         (CFG.frame_len == SER_ZERO && CFG.reset_len == st_q.act_period);
   endproperty
   a_period_reset_len: assert property (p_period_reset_len) else $error("reset length wrong");

   property p_exp_rolling;
      @(posedge CLOCK) disable iff (!RST_N)
      (!SHUTTER_GLOBAL) |=> (CFG.exp_ticks == SER_ZERO && CFG.exp_lines == st_q.act_integ);
   endproperty
   a_exp_rolling: assert property (p_exp_rolling) else $error("exposure units wrong");

   property p_mode_reset;
      @(posedge CLOCK)
      (!RST_N) |=> (st_q.regs.integ_ctrl[SER_BIT_PERIOD_MODE] && TICK == 1'b0);
   endproperty
   a_mode_reset: assert property (p_mode_reset) else $error("period mode reset wrong");

   property p_pad_hold;
      @(posedge CLOCK) disable iff (!RST_N)
      (sync_pad && !FRAME_START) |=> (st_q.act_pad == $past(st_q.act_pad));
   endproperty
   a_pad_hold: assert property (p_pad_hold) else $error("padding applied mid frame");

   property p_exp_direct;
      @(posedge CLOCK) disable iff (!RST_N)
      (!sync_exp && WR_EN && ADDR == SER_OFS_INTEG) |=> (st_q.act_integ == $past(WR_DATA));
   endproperty
   a_exp_direct: assert property (p_exp_direct) else $error("unsynced exposure late");

   property p_spare_readback;
      @(posedge CLOCK) disable iff (!RST_N)
      (WR_EN && ADDR == SER_OFS_SPARE_A) ##1 (!WR_EN) ##1
         (RD_EN && !WR_EN && ADDR == SER_OFS_SPARE_A) |=> (RD_DATA == $past(WR_DATA, 3));
   endproperty
   a_spare_readback: assert property (p_spare_readback) else $error("spare readback wrong");

   property p_dark_direct;
      @(posedge CLOCK) disable iff (!RST_N)
      (!sync_dark && WR_EN && ADDR == SER_OFS_DARK) |=>
         (CFG.dark_rows == $past(WR_DATA[SER_DARK_MSB:0]));
   endproperty
   a_dark_direct: assert property (p_dark_direct) else $error("unsynced dark count late");

   property p_gate_follow;
      @(posedge CLOCK) disable iff (!RST_N)
      (WR_EN && ADDR == SER_OFS_DARK) |=>
         (CFG.gate_first == $past(WR_DATA[SER_BIT_GATE_FIRST]));
   endproperty
   a_gate_follow: assert property (p_gate_follow) else $error("gating bit not stored");

   property p_pad_rolling;
      @(posedge CLOCK) disable iff (!RST_N)
      (!SHUTTER_GLOBAL) |=> (CFG.padding_rows == st_q.act_pad);
   endproperty
   a_pad_rolling: assert property (p_pad_rolling) else $error("padding lost in rolling");

   property p_tick_rolling;
      @(posedge CLOCK) disable iff (!RST_N)
      (!SHUTTER_GLOBAL) |=> (!TICK);
   endproperty
   a_tick_rolling: assert property (p_tick_rolling) else $error("tick in rolling shutter");

   property p_prescale_write;
      @(posedge CLOCK) disable iff (!RST_N)
      (WR_EN && ADDR == SER_OFS_PRESC) |=>
         (CFG.prescale == $past(WR_DATA));
   endproperty
   a_prescale_write: assert property (p_prescale_write) else $error("prescale not stored");

   property p_period_frame_len;
      @(posedge CLOCK) disable iff (!RST_N)
      (SHUTTER_GLOBAL && st_d.regs.integ_ctrl[SER_BIT_PERIOD_MODE]) |=>
         (CFG.reset_len == SER_ZERO && CFG.frame_len == st_q.act_period);
   endproperty
   a_period_frame_len: assert property (p_period_frame_len) else $error("frame length wrong");

   property p_exp_global;
      @(posedge CLOCK) disable iff (!RST_N)
      SHUTTER_GLOBAL |=> (CFG.exp_lines == SER_ZERO && CFG.exp_ticks == st_q.act_integ);
   endproperty
   a_exp_global: assert property (p_exp_global) else $error("global exposure units wrong");

   property p_exp_hold;
      @(posedge CLOCK) disable iff (!RST_N)
      (sync_exp && !FRAME_START) |=>
         (st_q.act_integ == $past(st_q.act_integ) && st_q.act_period == $past(st_q.act_period));
   endproperty
   a_exp_hold: assert property (p_exp_hold) else $error("exposure applied mid frame");

   property p_pad_direct;
      @(posedge CLOCK) disable iff (!RST_N)
      (!sync_pad && WR_EN && ADDR == SER_OFS_PAD) |=>
         (st_q.act_pad == $past(WR_DATA[SER_PAD_MSB:0]));
   endproperty
   a_pad_direct: assert property (p_pad_direct) else $error("unsynced padding late");

endmodule

// ===== ser_host_model.sv
// Host model that drives the register access port of the exposure register bank
`timescale 1ns/1ps

module ser_host_model
   import ser_pkg::*;
(
   input  wire logic              clock,
   output logic                   wr_en,
   output logic                   rd_en,
   output logic      [SER_AW-1:0] addr,
   output logic      [SER_DW-1:0] wr_data,
   input  wire logic [SER_DW-1:0] rd_data
);
   initial
   begin
      wr_en   = 1'b0;
      rd_en   = 1'b0;
      addr    = '0;
      wr_data = '0;
   end

   // One strobe cycle per access; idle data is inverted so a stale word never looks valid
   task automatic wr(input logic [SER_AW-1:0] a, input logic [SER_DW-1:0] d);
      @(posedge clock);
      #1;
      wr_en   = 1'b1;
      addr    = a;
      wr_data = d;
      @(posedge clock);
      #1;
      wr_en   = 1'b0;
      wr_data = ~d;
   endtask

   // Read data is registered at the strobe edge and holds, so it is taken just after it
   task automatic rd(input logic [SER_AW-1:0] a, output logic [SER_DW-1:0] d);
      @(posedge clock);
      #1;
      rd_en = 1'b1;
      addr  = a;
      @(posedge clock);
      #1;
      rd_en = 1'b0;
      d     = rd_data;
   endtask
endmodule

// ===== test_ser_exposure_regs.sv
// Self-checking testbench of the exposure timing register bank
`timescale 1ns/1ps

module test_ser_exposure_regs
   import ser_pkg::*;
();
   logic              clock;
   logic              rst_n;
   logic              frame_start;
   logic              first_line;
   logic              shutter_global;
   logic              wr_en;
   logic              rd_en;
   logic [SER_AW-1:0] addr;
   logic [SER_DW-1:0] wr_data;
   logic [SER_DW-1:0] rd_data;
   logic              blank_line;
   logic              tick;
   ser_timing_t       cfg;
   int                err_count   = 0;
   int                check_count = 0;
   int                cycles      = 0;
   logic [3:0]        ra [11] = '{4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'he};
   logic [15:0]       rv [11] = '{16'h0004, 16'h0000, 16'h0102, 16'h0000, 16'h0001, 16'h0000,
                                  16'h0000, 16'h0000, 16'h0000, 16'h01e2, 16'h033f};
   logic [3:0]        ua [5]  = '{4'h0, 4'h1, 4'h3, 4'hd, 4'hf};

   ser_exposure_regs i_dut (.CLOCK(clock), .RST_N(rst_n), .WR_EN(wr_en), .RD_EN(rd_en),
      .ADDR(addr), .WR_DATA(wr_data), .RD_DATA(rd_data), .FRAME_START(frame_start),
      .FIRST_LINE(first_line), .SHUTTER_GLOBAL(shutter_global), .BLANK_LINE(blank_line),
      .TICK(tick), .CFG(cfg));

   ser_host_model i_host (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wr_data(wr_data), .rd_data(rd_data));

   // ****************************************
   // Clock, timeout and report
   // ****************************************
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Whole sequence needs well under a thousand cycles
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic rdchk(input string name, input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] v;
      i_host.rd(a, v);
      check(name, v, exp);
   endtask

   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask

   task automatic frame();
      @(posedge clock);
      #1;
      frame_start = 1'b1;
      @(posedge clock);
      #1;
      frame_start = 1'b0;
      settle();
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      int n;
      rst_n          = 1'b0;
      frame_start    = 1'b0;
      first_line     = 1'b0;
      shutter_global = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 11; i++)
         rdchk("reset value", ra[i], rv[i]);
      check("dark rows", 16'(cfg.dark_rows), 16'h0002);
      check("gate first", 16'(cfg.gate_first), 16'h0001);
      check("prescale", cfg.prescale, 16'h0001);
      check("col gain", 16'(cfg.col_gain), 16'h0002);
      $display("test reset values done");

      i_host.wr(4'ha, 16'ha5c3);
      rdchk("spare a", 4'ha, 16'ha5c3);
      i_host.wr(4'ha, 16'h0000);
      for (int i = 0; i < 5; i++)
      begin
         i_host.wr(ua[i], 16'hffff);
         rdchk("unmapped", ua[i], 16'h0000);
      end
      rdchk("region after unmapped", 4'h4, 16'h0000);
      i_host.wr(4'h4, 16'hff80);
      settle();
      check("region all", 16'(cfg.region_en), 16'h01ff);
      i_host.wr(4'h4, 16'h7f7f);
      settle();
      check("region mixed", 16'(cfg.region_en), 16'h00fe);
      rdchk("region loose bits", 4'h4, 16'h7f7f);
      i_host.wr(4'hc, 16'hffff);
      check("col gain loose", 16'(cfg.col_gain), 16'h001f);
      rdchk("gain loose bits", 4'hc, 16'hffff);
      $display("test storage and regions done");

      first_line = 1'b1;
      @(posedge clock);
      #1;
      check("blank on", 16'(blank_line), 16'h0001);
      first_line = 1'b0;
      i_host.wr(4'h5, 16'h0005);
      settle();
      first_line = 1'b1;
      @(posedge clock);
      #1;
      check("blank off", 16'(blank_line), 16'h0000);
      first_line = 1'b0;
      check("dark held", 16'(cfg.dark_rows), 16'h0002);
      check("gate off", 16'(cfg.gate_first), 16'h0000);
      frame();
      check("dark applied", 16'(cfg.dark_rows), 16'h0005);
      $display("test dark rows done");

      i_host.wr(4'h6, 16'h0fff);
      settle();
      check("pad held", 16'(cfg.padding_rows), 16'h0000);
      frame();
      check("pad applied", 16'(cfg.padding_rows), 16'h0fff);
      shutter_global = 1'b1;
      settle();
      check("pad global", 16'(cfg.padding_rows), 16'h0000);
      i_host.wr(4'h8, 16'h0030);
      i_host.wr(4'h9, 16'h0011);
      settle();
      check("frame len held", cfg.frame_len, 16'h0000);
      check("ticks held", cfg.exp_ticks, 16'h0000);
      frame();
      check("frame len", cfg.frame_len, 16'h0030);
      check("reset len", cfg.reset_len, 16'h0000);
      check("exp ticks", cfg.exp_ticks, 16'h0011);
      check("exp lines global", cfg.exp_lines, 16'h0000);
      i_host.wr(4'h2, 16'h0000);
      settle();
      check("reset len mode0", cfg.reset_len, 16'h0030);
      check("frame len mode0", cfg.frame_len, 16'h0000);
      shutter_global = 1'b0;
      settle();
      check("exp lines", cfg.exp_lines, 16'h0011);
      check("exp ticks rolling", cfg.exp_ticks, 16'h0000);
      $display("test shadowed timing done");

      i_host.wr(4'he, 16'h0000);
      i_host.wr(4'h9, 16'h0022);
      i_host.wr(4'h6, 16'h0007);
      i_host.wr(4'h5, 16'h0107);
      settle();
      check("exp lines unsynced", cfg.exp_lines, 16'h0022);
      check("pad unsynced", 16'(cfg.padding_rows), 16'h0007);
      check("dark unsynced", 16'(cfg.dark_rows), 16'h0007);
      check("gate on again", 16'(cfg.gate_first), 16'h0001);
      $display("test unsynced update done");

      i_host.wr(4'h7, 16'h0003);
      check("tick rolling", 16'(tick), 16'h0000);
      check("prescale set", cfg.prescale, 16'h0003);
      shutter_global = 1'b1;
      n = 0;
      while (tick !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      n = 0;
      do
      begin
         @(posedge clock);
         #1;
         n++;
      end
      while (tick !== 1'b1 && n < 20);
      check("tick period", 16'(n), 16'h0003);
      $display("test prescaler done");
      tally_and_finish();
   end
endmodule
